/* logic/dsec_pkg.sv */
// Contract
// - Status direction bit: one read, zero write
// - Status holds last active channel number
// - Address register captures last access, resets zero
// - Status upper bits read zero, ignore writes
// - Per-channel flag and enable, eight channels; the reduced variant keeps flags and enables for channels 0 to 3 only
// - Clear, set, invert aliases at 4, 8, C
// - Force starts, abort aborts, both read zero
// - Enabled matching start irq begins cell transfer
// - Enabled matching abort irq aborts, sets flag
package dsec_pkg;

   localparam int          NUM_CH          = 8;
   localparam int          ADDR_W          = 12;

   localparam logic [11:0] OFS_STATUS      = 12'h000;
   localparam logic [11:0] OFS_ADDRESS     = 12'h010;
   localparam logic [11:0] OFS_FLAG        = 12'h020;
   localparam logic [11:0] OFS_ENABLE      = 12'h030;
   localparam logic [11:0] OFS_ECON_BASE   = 12'h100;

   localparam logic [1:0]  OP_WRITE        = 2'h0;
   localparam logic [1:0]  OP_CLR          = 2'h1;
   localparam logic [1:0]  OP_SET          = 2'h2;
   localparam logic [1:0]  OP_INV          = 2'h3;

   localparam logic [3:0]  SEL_STATUS      = 4'h0;
   localparam logic [3:0]  SEL_ADDRESS     = 4'h1;
   localparam logic [3:0]  SEL_FLAG        = 4'h2;
   localparam logic [3:0]  SEL_ENABLE      = 4'h3;
   localparam logic [3:0]  SEL_NONE        = 4'h4;

   localparam int          STAT_DIR_BIT    = 3;
   localparam int          ECON_ASEL_LSB   = 16;
   localparam int          ECON_SSEL_LSB   = 8;
   localparam int          ECON_FORCE_BIT  = 7;
   localparam int          ECON_ABORT_BIT  = 6;
   localparam int          ECON_PAT_BIT    = 5;
   localparam int          ECON_SEN_BIT    = 4;
   localparam int          ECON_AEN_BIT    = 3;
   localparam logic [31:0] ECON_RESET      = 32'h00FF_FF00;
   localparam logic [31:0] ECON_RW_MASK    = 32'h00FF_FF38;
   localparam logic [31:0] ADDR_RESET      = 32'h0000_0000;
   localparam logic [7:0]  CH_MASK_FULL    = 8'hFF;
   localparam logic [7:0]  CH_MASK_REDUCED = 8'h0F;

   localparam logic [1:0]  RESP_OKAY       = 2'h0;
   localparam logic [1:0]  RESP_DECERR     = 2'h3;

   typedef struct packed {
      logic        valid;
      logic        rd;
      logic [2:0]  ch;
      logic [31:0] addr;
   } dsec_access_t;

   typedef struct packed {
      logic        valid;
      logic [7:0]  num;
   } dsec_irq_t;

   // Byte lanes expanded to a bit mask
   function automatic logic [31:0] dsec_lanes(input logic [3:0] strb);
      logic [31:0] m;
      m = 32'h0000_0000;
      for (int i = 0; i < 4; i++)
      begin
         m[i*8 +: 8] = {8{strb[i]}};
      end
      return m;
   endfunction

   // Plain write or clear/set/invert alias on the written lanes
   function automatic logic [31:0] dsec_apply(input logic [31:0] cur,
                                              input logic [31:0] wd,
                                              input logic [3:0]  strb,
                                              input logic [1:0]  op);
      logic [31:0] m;
      logic [31:0] b;
      m = dsec_lanes(strb);
      b = wd & m;
      case (op)
         OP_CLR:  return cur & ~b;
         OP_SET:  return cur | b;
         OP_INV:  return cur ^ b;
         default: return (cur & ~m) | b;
      endcase
   endfunction

   // Register selector; channel n decodes to 8+n
   function automatic logic [3:0] dsec_decode(input logic [11:0] a);
      logic [3:0] s;
      s = SEL_NONE;
      if (a[1:0] != 2'h0)
         s = SEL_NONE;
      else if (a == OFS_STATUS)
         s = SEL_STATUS;
      else if (a == OFS_ADDRESS)
         s = SEL_ADDRESS;
      else if (a[11:4] == OFS_FLAG[11:4])
         s = SEL_FLAG;
      else if (a[11:4] == OFS_ENABLE[11:4])
         s = SEL_ENABLE;
      else if (a[11:7] == OFS_ECON_BASE[11:7])
         s = {1'b1, a[6:4]};
      return s;
   endfunction

endpackage

/* logic/dsec_chan_evt.sv */
// One channel's event-control register and its start/abort triggers
`timescale 1ns/1ps
module dsec_chan_evt
(
   input  wire logic              i_clk,
   input  wire logic              i_resetn,
   input  wire logic              i_wr,
   input  wire logic [1:0]        i_op,
   input  wire logic [31:0]       i_wdata,
   input  wire logic [3:0]        i_wstrb,
   input  wire dsec_pkg::dsec_irq_t i_irq,
   output logic      [31:0]       o_econ,
   output logic                   o_start,
   output logic                   o_abort,
   output logic                   o_abort_evt
);
   import dsec_pkg::*;

   logic [31:0] econ_q;
   logic [31:0] econ_d;
   logic        start_q;
   logic        start_d;
   logic        abort_q;
   logic        abort_d;
   logic        evt_q;
   logic        evt_d;
   logic [31:0] bits;
   logic        trig_ok;
   logic        s_hit;
   logic        a_hit;

   always_comb
   begin
      bits    = i_wdata & dsec_lanes(i_wstrb);
      trig_ok = i_wr && (i_op != OP_CLR);
      econ_d  = econ_q;
      if (i_wr)
      begin
         // Force and abort are never stored, so they read zero
         econ_d = dsec_apply(econ_q, i_wdata, i_wstrb, i_op) & ECON_RW_MASK;
      end
      s_hit = i_irq.valid && econ_q[ECON_SEN_BIT]
              && (i_irq.num == econ_q[ECON_SSEL_LSB +: 8]);
      a_hit = i_irq.valid && econ_q[ECON_AEN_BIT]
              && (i_irq.num == econ_q[ECON_ASEL_LSB +: 8]);
      start_d = (trig_ok && bits[ECON_FORCE_BIT]) || s_hit;
      abort_d = (trig_ok && bits[ECON_ABORT_BIT]) || a_hit;
      evt_d   = a_hit;
   end

   always_ff @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         econ_q  <= ECON_RESET;
         start_q <= 1'b0;
         abort_q <= 1'b0;
         evt_q   <= 1'b0;
      end
      else
      begin
         econ_q  <= econ_d;
         start_q <= start_d;
         abort_q <= abort_d;
         evt_q   <= evt_d;
      end
   end

   assign o_econ      = econ_q;
   assign o_start     = start_q;
   assign o_abort     = abort_q;
   assign o_abort_evt = evt_q;

endmodule

/* logic/dsec_top.sv */
// DMA last-access status, address trace, channel event control and flags over AXI4-Lite
//
// Added by the designer: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ps
module dsec_top
#(
   parameter logic P_FULL_VARIANT = 1'b1
)
(
   input  wire logic                   i_clk,
   input  wire logic                   i_resetn,
   input  wire logic                   i_axi_awvalid,
   output logic                        o_axi_awready,
   input  wire logic [11:0]            i_axi_awaddr,
   input  wire logic                   i_axi_wvalid,
   output logic                        o_axi_wready,
   input  wire logic [31:0]            i_axi_wdata,
   input  wire logic [3:0]             i_axi_wstrb,
   output logic                        o_axi_bvalid,
   input  wire logic                   i_axi_bready,
   output logic      [1:0]             o_axi_bresp,
   input  wire logic                   i_axi_arvalid,
   output logic                        o_axi_arready,
   input  wire logic [11:0]            i_axi_araddr,
   output logic                        o_axi_rvalid,
   input  wire logic                   i_axi_rready,
   output logic      [31:0]            o_axi_rdata,
   output logic      [1:0]             o_axi_rresp,
   input  wire dsec_pkg::dsec_access_t i_access,
   input  wire dsec_pkg::dsec_irq_t    i_irq,
   output logic      [7:0]             o_start,
   output logic      [7:0]             o_abort,
   output logic                        o_irq
);
   import dsec_pkg::*;

   // Reduced parts have no flags or enables for channels 4 to 7
   localparam logic [7:0] CH_MASK = P_FULL_VARIANT ? CH_MASK_FULL : CH_MASK_REDUCED;

   // Write channel state
   logic        aw_have_q;
   logic        aw_have_d;
   logic [11:0] awaddr_q;
   logic [11:0] awaddr_d;
   logic        w_have_q;
   logic        w_have_d;
   logic [31:0] wdata_q;
   logic [31:0] wdata_d;
   logic [3:0]  wstrb_q;
   logic [3:0]  wstrb_d;
   logic        bvalid_q;
   logic        bvalid_d;
   logic [1:0]  bresp_q;
   logic [1:0]  bresp_d;

   // Read channel state
   logic        rvalid_q;
   logic        rvalid_d;
   logic [31:0] rdata_q;
   logic [31:0] rdata_d;
   logic [1:0]  rresp_q;
   logic [1:0]  rresp_d;

   // Trace and flag state
   logic        dir_q;
   logic        dir_d;
   logic [2:0]  chan_q;
   logic [2:0]  chan_d;
   logic [31:0] addr_q;
   logic [31:0] addr_d;
   logic [7:0]  flag_q;
   logic [7:0]  flag_d;
   logic [7:0]  en_q;
   logic [7:0]  en_d;
   logic        irq_q;
   logic        irq_d;

   logic        do_wr;
   logic        ar_fire;
   logic [3:0]  wr_sel;
   logic [3:0]  rd_sel;
   logic [1:0]  wr_op;
   logic [31:0] econ     [NUM_CH];
   logic [7:0]  ch_wr;
   logic [7:0]  abort_evt;

   assign o_axi_awready = !aw_have_q;
   assign o_axi_wready  = !w_have_q;
   // Arready drops while a read answer waits, so one read is in flight
   assign o_axi_arready = !rvalid_q;
   // A write retires only once the previous response has been taken
   assign do_wr         = aw_have_q && w_have_q && !bvalid_q;
   assign ar_fire       = i_axi_arvalid && !rvalid_q;
   assign wr_sel        = dsec_decode(awaddr_q);
   assign rd_sel        = dsec_decode(i_axi_araddr);
   // Address bits 3:2 pick plain write, clear, set or invert
   assign wr_op         = awaddr_q[3:2];

   // Write address and data taken in either order, answered once both are held
   always_comb
   begin
      aw_have_d = aw_have_q;
      awaddr_d  = awaddr_q;
      w_have_d  = w_have_q;
      wdata_d   = wdata_q;
      wstrb_d   = wstrb_q;
      bvalid_d  = bvalid_q;
      bresp_d   = bresp_q;
      if (i_axi_awvalid && !aw_have_q)
      begin
         aw_have_d = 1'b1;
         awaddr_d  = i_axi_awaddr;
      end
      if (i_axi_wvalid && !w_have_q)
      begin
         w_have_d = 1'b1;
         wdata_d  = i_axi_wdata;
         wstrb_d  = i_axi_wstrb;
      end
      if (bvalid_q && i_axi_bready)
      begin
         bvalid_d = 1'b0;
      end
      if (do_wr)
      begin
         aw_have_d = 1'b0;
         w_have_d  = 1'b0;
         bvalid_d  = 1'b1;
         // Read-only registers accept the write and ignore it
         bresp_d   = (wr_sel == SEL_NONE) ? RESP_DECERR : RESP_OKAY;
      end
   end

   always_ff @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         aw_have_q <= 1'b0;
         awaddr_q  <= 12'h000;
         w_have_q  <= 1'b0;
         wdata_q   <= 32'h0000_0000;
         wstrb_q   <= 4'h0;
         bvalid_q  <= 1'b0;
         bresp_q   <= RESP_OKAY;
      end
      else
      begin
         aw_have_q <= aw_have_d;
         awaddr_q  <= awaddr_d;
         w_have_q  <= w_have_d;
         wdata_q   <= wdata_d;
         wstrb_q   <= wstrb_d;
         bvalid_q  <= bvalid_d;
         bresp_q   <= bresp_d;
      end
   end

   assign o_axi_bvalid = bvalid_q;
   assign o_axi_bresp  = bresp_q;

   // Read data registered one cycle after the address is taken
   always_comb
   begin
      rvalid_d = rvalid_q;
      rdata_d  = rdata_q;
      rresp_d  = rresp_q;
      if (rvalid_q && i_axi_rready)
      begin
         rvalid_d = 1'b0;
      end
      if (ar_fire)
      begin
         rvalid_d = 1'b1;
         rresp_d  = RESP_OKAY;
         rdata_d  = 32'h0000_0000;
         if (rd_sel == SEL_STATUS)
         begin
            rdata_d[STAT_DIR_BIT] = dir_q;
            rdata_d[2:0]          = chan_q;
         end
         else if (rd_sel == SEL_ADDRESS)
            rdata_d = addr_q;
         else if (rd_sel == SEL_FLAG)
            rdata_d[7:0] = flag_q;
         else if (rd_sel == SEL_ENABLE)
            rdata_d[7:0] = en_q;
         else if (rd_sel[3])
            rdata_d = econ[rd_sel[2:0]];
         // Unmapped reads return zero with a decode error
         else
            rresp_d = RESP_DECERR;
      end
   end

   always_ff @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         rvalid_q <= 1'b0;
         rdata_q  <= 32'h0000_0000;
         rresp_q  <= RESP_OKAY;
      end
      else
      begin
         rvalid_q <= rvalid_d;
         rdata_q  <= rdata_d;
         rresp_q  <= rresp_d;
      end
   end

   assign o_axi_rvalid = rvalid_q;
   assign o_axi_rdata  = rdata_q;
   assign o_axi_rresp  = rresp_q;

   // Last bus access trace
   always_comb
   begin
      dir_d  = dir_q;
      chan_d = chan_q;
      addr_d = addr_q;
      if (i_access.valid)
      begin
         dir_d  = i_access.rd;
         chan_d = i_access.ch;
         addr_d = i_access.addr;
      end
   end

   always_ff @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         dir_q  <= 1'b0;
         chan_q <= 3'h0;
         addr_q <= ADDR_RESET;
      end
      else
      begin
         dir_q  <= dir_d;
         chan_q <= chan_d;
         addr_q <= addr_d;
      end
   end

   // Sticky abort flags, their enables and the registered interrupt level
   always_comb
   begin
      flag_d = flag_q;
      en_d   = en_q;
      if (do_wr && wr_sel == SEL_FLAG)
         flag_d = 8'(dsec_apply({24'h0, flag_q}, wdata_q, wstrb_q, wr_op));
      if (do_wr && wr_sel == SEL_ENABLE)
         en_d = 8'(dsec_apply({24'h0, en_q}, wdata_q, wstrb_q, wr_op));
      // Reading the flags returns the old value and clears them
      if (ar_fire && rd_sel == SEL_FLAG)
         flag_d = 8'h00;
      // A new abort event wins over a clear in the same cycle
      flag_d = (flag_d | abort_evt) & CH_MASK;
      en_d   = en_d & CH_MASK;
      // Taken from the next values so the pin moves with the flags
      irq_d  = |(flag_d & en_d);
   end

   always_ff @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         flag_q <= 8'h00;
         en_q   <= 8'h00;
         irq_q  <= 1'b0;
      end
      else
      begin
         flag_q <= flag_d;
         en_q   <= en_d;
         irq_q  <= irq_d;
      end
   end

   assign o_irq = irq_q;

   // One event-control block per channel
   for (genvar g = 0; g < NUM_CH; g++)
   begin : g_ch
      // Each channel sees only writes decoded to its own register
      assign ch_wr[g] = do_wr && (wr_sel == {1'b1, 3'(g)});
      dsec_chan_evt u_evt
      (
         .i_clk       (i_clk),
         .i_resetn    (i_resetn),
         .i_wr        (ch_wr[g]),
         .i_op        (wr_op),
         .i_wdata     (wdata_q),
         .i_wstrb     (wstrb_q),
         .i_irq       (i_irq),
         .o_econ      (econ[g]),
         .o_start     (o_start[g]),
         .o_abort     (o_abort[g]),
         .o_abort_evt (abort_evt[g])
      );
   end

endmodule

/* test/dsec_top_assertions.sv */
// Port-level checker for the DMA status and event-control block
`timescale 1ns/1ps
module dsec_top_assertions
#(
   parameter logic P_FULL_VARIANT = 1'b1
)
(
   input wire logic                   i_clk,
   input wire logic                   i_resetn,
   input wire logic                   i_axi_arvalid,
   input wire logic                   o_axi_arready,
   input wire logic [11:0]            i_axi_araddr,
   input wire logic                   o_axi_rvalid,
   input wire logic [31:0]            o_axi_rdata,
   input wire logic                   o_axi_bvalid,
   input wire dsec_pkg::dsec_access_t i_access,
   input wire dsec_pkg::dsec_irq_t    i_irq,
   input wire logic [7:0]             o_start,
   input wire logic [7:0]             o_abort,
   input wire logic                   o_irq
);
   import dsec_pkg::*;
   logic [11:0] ar_q;
   logic        new_q, clash_q, rd_q;
   logic [2:0]  ch_q;
   logic [31:0] ad_q;
   logic        st_rd, ad_rd, ec_rd, fl_rd;
   // Shadow of the last access; a read taken with an access in the same cycle is not judged
   always_ff @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         ar_q    <= 12'h000;
         new_q   <= 1'b0;
         clash_q <= 1'b0;
         rd_q    <= 1'b0;
         ch_q    <= 3'h0;
         ad_q    <= 32'h0000_0000;
      end
      else
      begin
         new_q   <= i_axi_arvalid && o_axi_arready;
         if (i_axi_arvalid && o_axi_arready)
         begin
            ar_q    <= i_axi_araddr;
            clash_q <= i_access.valid;
         end
         if (i_access.valid)
         begin
            rd_q <= i_access.rd;
            ch_q <= i_access.ch;
            ad_q <= i_access.addr;
         end
      end
   end
   assign st_rd = new_q && !clash_q && ar_q == OFS_STATUS;
   assign ad_rd = new_q && !clash_q && ar_q == OFS_ADDRESS;
   assign ec_rd = new_q && ar_q[11:7] == OFS_ECON_BASE[11:7] && ar_q[1:0] == 2'h0;
   assign fl_rd = new_q && ar_q[11:4] == OFS_FLAG[11:4] && ar_q[1:0] == 2'h0;
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_resetn);
   chk_status_dir: assert property (st_rd |-> o_axi_rvalid && o_axi_rdata[STAT_DIR_BIT] == rd_q)
      else $error("status direction bit wrong");
   chk_status_chan: assert property (st_rd |-> o_axi_rdata[2:0] == ch_q)
      else $error("status channel field wrong");
   chk_status_upper: assert property (st_rd |-> o_axi_rdata[31:4] == 28'h0)
      else $error("status upper bits not zero");
   chk_addr_trace: assert property (ad_rd |-> o_axi_rdata == ad_q)
      else $error("address trace wrong");
   chk_econ_zeros: assert property (ec_rd |-> (o_axi_rdata & 32'hFF00_00C7) == 32'h0)
      else $error("event control zero bits set");
   chk_flag_width: assert property (fl_rd |-> o_axi_rdata[31:8] == 24'h0 && (P_FULL_VARIANT || o_axi_rdata[7:4] == 4'h0))
      else $error("flag bits beyond channels");
   chk_start_cause: assert property (o_start != 8'h0 |-> $past(i_irq.valid) || o_axi_bvalid || $past(o_axi_bvalid))
      else $error("start pulse without cause");
   chk_abort_cause: assert property (o_abort != 8'h0 |-> $past(i_irq.valid) || o_axi_bvalid || $past(o_axi_bvalid))
      else $error("abort pulse without cause");
   chk_reset_quiet: assert property ($rose(i_resetn) |-> o_start == 8'h0 && o_abort == 8'h0 && !o_irq)
      else $error("outputs active after reset");
   cover property (o_start != 8'h0);
   cover property (o_abort != 8'h0);
   cover property (o_irq);
   cover property (st_rd);
endmodule
bind dsec_top dsec_top_assertions #(.P_FULL_VARIANT(P_FULL_VARIANT)) u_chk (.i_clk(i_clk), .i_resetn(i_resetn),
   .i_axi_arvalid(i_axi_arvalid), .o_axi_arready(o_axi_arready), .i_axi_araddr(i_axi_araddr),
   .o_axi_rvalid(o_axi_rvalid), .o_axi_rdata(o_axi_rdata), .o_axi_bvalid(o_axi_bvalid), .i_access(i_access),
   .i_irq(i_irq), .o_start(o_start), .o_abort(o_abort), .o_irq(o_irq));

/* test/dsec_far_model.sv */
// Far-side model: DMA bus accesses and interrupt request sources
`timescale 1ns/1ps
module dsec_far_model
(
   input  wire logic              i_clk,
   output dsec_pkg::dsec_access_t o_access,
   output dsec_pkg::dsec_irq_t    o_irq
);
   import dsec_pkg::*;
   initial
   begin
      o_access = '0;
      o_irq    = '0;
   end
   // One-cycle event; the payload is scrambled once released
   task automatic access(input logic rd, input logic [2:0] ch, input logic [31:0] ad);
      @(posedge i_clk);
      o_access <= '{1'b1, rd, ch, ad};
      @(posedge i_clk);
      o_access <= '{1'b0, ~rd, ~ch, ~ad};
   endtask
   task automatic irq(input logic [7:0] num);
      @(posedge i_clk);
      o_irq <= '{1'b1, num};
      @(posedge i_clk);
      o_irq <= '{1'b0, ~num};
   endtask
endmodule

/* test/dsec_top_bench.sv */
// Self-checking bench for the DMA status and event-control block
`timescale 1ns/1ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin fails++; $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end
module dsec_top_bench;
   import dsec_pkg::*;
   logic                clk, rstn, awv, wv, bre, arv, rre, awr, wr, bv, arr, rv, oirq, b;
   logic         [11:0] awa, ara;
   logic         [31:0] wd, rdat, x, cur, en, d;
   logic         [3:0]  ws;
   logic         [1:0]  br, rr, r;
   logic         [7:0]  st, ab, s, a;
   logic         [2:0]  c;
   dsec_access_t        acc;
   dsec_irq_t           irq;
   logic         [31:0] rdat_r;
   logic                oirq_r;
   int                  fails, check_count, i, n;
   int                  sc [8], ac [8], es [8], ea [8];
   dsec_top DUT (.i_clk(clk), .i_resetn(rstn), .i_axi_awvalid(awv), .o_axi_awready(awr), .i_axi_awaddr(awa),
      .i_axi_wvalid(wv), .o_axi_wready(wr), .i_axi_wdata(wd), .i_axi_wstrb(ws), .o_axi_bvalid(bv),
      .i_axi_bready(bre), .o_axi_bresp(br), .i_axi_arvalid(arv), .o_axi_arready(arr), .i_axi_araddr(ara),
      .o_axi_rvalid(rv), .i_axi_rready(rre), .o_axi_rdata(rdat), .o_axi_rresp(rr), .i_access(acc),
      .i_irq(irq), .o_start(st), .o_abort(ab), .o_irq(oirq));
   dsec_far_model u_far (.i_clk(clk), .o_access(acc), .o_irq(irq));
   // Reduced variant in lockstep; only its read data and interrupt are judged
   dsec_top #(.P_FULL_VARIANT(1'b0)) DUT_R (.i_clk(clk), .i_resetn(rstn), .i_axi_awvalid(awv),
      .o_axi_awready(), .i_axi_awaddr(awa), .i_axi_wvalid(wv), .o_axi_wready(), .i_axi_wdata(wd),
      .i_axi_wstrb(ws), .o_axi_bvalid(), .i_axi_bready(bre), .o_axi_bresp(), .i_axi_arvalid(arv),
      .o_axi_arready(), .i_axi_araddr(ara), .o_axi_rvalid(), .i_axi_rready(rre), .o_axi_rdata(rdat_r),
      .o_axi_rresp(), .i_access(acc), .i_irq(irq), .o_start(), .o_abort(), .o_irq(oirq_r));
   always #10 clk = ~clk;
   // Pulses are counted away from the launching edge
   always @(negedge clk)
      for (int k = 0; k < 8; k++)
      begin
         if (st[k] === 1'b1) sc[k]++;
         if (ab[k] === 1'b1) ac[k]++;
      end
   function automatic logic [31:0] alias_f(input logic [31:0] cv, input logic [31:0] w, input int op);
      case (op)
         1: return cv & ~w;
         2: return cv | w;
         3: return cv ^ w;
         default: return w;
      endcase
   endfunction
   function automatic logic [11:0] ea_f(input int k);
      return OFS_ECON_BASE + 12'(16 * k);
   endfunction
   task automatic wr32(input logic [11:0] ad, input logic [31:0] v, input logic [1:0] er);
      logic ah, wh;
      ah = 1'b0;
      wh = 1'b0;
      @(posedge clk);
      awv <= 1; awa <= ad; wv <= 1; wd <= v; ws <= 4'hF; bre <= 1;
      while (!(ah && wh))
      begin
         @(negedge clk);
         ah = ah | (awv & awr);
         wh = wh | (wv & wr);
         @(posedge clk);
         if (ah) awv <= 0;
         if (wh) wv <= 0;
      end
      @(negedge clk);
      while (bv !== 1'b1) @(negedge clk);
      `CHK(br, er)
      @(posedge clk);
      bre <= 0;
   endtask
   task automatic rchk(input logic [11:0] ad, input logic [31:0] e, input logic [1:0] er);
      @(posedge clk);
      arv <= 1; ara <= ad; rre <= 1;
      @(negedge clk);
      while (arr !== 1'b1) @(negedge clk);
      @(posedge clk);
      arv <= 0;
      @(negedge clk);
      while (rv !== 1'b1) @(negedge clk);
      `CHK({rdat, rr}, {e, er})
      @(posedge clk);
      rre <= 0;
   endtask
   task automatic results;
      $display("Comparisons %0d, mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   initial
   begin
      #400000;
      fails++;
      results();
   end
   initial
   begin
      clk = 0; rstn = 0; awv = 0; wv = 0; bre = 0; arv = 0; rre = 0; awa = 0; ara = 0; wd = 0; ws = 0;
      void'($urandom(29830));
      repeat (16) @(posedge clk);
      rstn <= 1;
      rchk(OFS_STATUS, 32'h0, RESP_OKAY);
      rchk(OFS_ADDRESS, ADDR_RESET, RESP_OKAY);
      for (n = 0; n < 8; n++) rchk(ea_f(n), ECON_RESET, RESP_OKAY);
      rchk(12'h0F0, 32'h0, RESP_DECERR);
      for (i = 0; i < 12; i++)
      begin
         x = (i == 0) ? 32'hFFFF_FFFF : $urandom;
         c = (i == 0) ? 3'h7 : 3'($urandom);
         b = ~i[0];
         u_far.access(b, c, x);
         rchk(OFS_STATUS, {28'h0, b, c}, RESP_OKAY);
         rchk(OFS_ADDRESS, x, RESP_OKAY);
      end
      wr32(OFS_STATUS, 32'hFFFF_FFFF, RESP_OKAY);
      wr32(OFS_ADDRESS, 32'h0, RESP_OKAY);
      rchk(OFS_STATUS, {28'h0, b, c}, RESP_OKAY);
      rchk(OFS_ADDRESS, x, RESP_OKAY);
      wr32(OFS_ENABLE, 32'hFFFF_FFFF, RESP_OKAY);
      en = 32'hFF;
      rchk(OFS_ENABLE, en, RESP_OKAY);
      `CHK(rdat_r, 32'h0F)
      for (i = 1; i < 4; i++)
      begin
         x = $urandom;
         wr32(OFS_ENABLE + 12'(4 * i), x, RESP_OKAY);
         en = alias_f(en, x, i) & 32'hFF;
         rchk(OFS_ENABLE, en, RESP_OKAY);
         `CHK(rdat_r, en & 32'h0F)
      end
      for (n = 0; n < 8; n++)
      begin
         s = $urandom;
         a = s + 8'h01;
         cur = {8'h00, a, s, 8'h18};
         wr32(ea_f(n), cur | 32'hFF00_00C7, RESP_OKAY);
         es[n]++;
         ea[n]++;
         rchk(ea_f(n), cur, RESP_OKAY);
         u_far.irq(s);
         u_far.irq(a);
         u_far.irq(a + 8'h01);
         es[n]++;
         ea[n]++;
         repeat (4) @(posedge clk);
         `CHK(sc[n], es[n])
         `CHK(ac[n], ea[n])
         @(negedge clk);
         `CHK(oirq, en[n])
         `CHK(oirq_r, en[n] && n < 4)
         rchk(OFS_FLAG, 32'h1 << n, RESP_OKAY);
         `CHK(rdat_r, (32'h1 << n) & 32'h0F)
         @(negedge clk);
         `CHK(oirq, 1'b0)
         wr32(ea_f(n) + 12'h4, 32'h10, RESP_OKAY);
         cur = cur & ~32'h10;
         u_far.irq(s);
         rchk(ea_f(n), cur, RESP_OKAY);
         for (i = 1; i < 4; i++)
         begin
            x = $urandom;
            wr32(ea_f(n) + 12'(4 * i), x, RESP_OKAY);
            if (i > 1) es[n] += x[7];
            if (i > 1) ea[n] += x[6];
            cur = alias_f(cur, x, i) & ECON_RW_MASK;
            rchk(ea_f(n), cur, RESP_OKAY);
         end
         repeat (4) @(posedge clk);
         `CHK(sc[n], es[n])
         `CHK(ac[n], ea[n])
         wr32(ea_f(n), ECON_RESET, RESP_OKAY);
      end
      // Mid-run reset brings trace and enables back to their reset values
      rstn <= 0;
      repeat (3) @(posedge clk);
      rstn <= 1;
      rchk(OFS_STATUS, 32'h0, RESP_OKAY);
      rchk(OFS_ADDRESS, ADDR_RESET, RESP_OKAY);
      rchk(OFS_ENABLE, 32'h0, RESP_OKAY);
      results();
   end
endmodule
